/* File: design/video_interrupt_mask_pkg.sv */
// package: register map, field positions and reset values of the interrupt enable block
package video_interrupt_mask_pkg;
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 32;
    // register indices on the plain port
    localparam logic [3:0]  OFS_MASK         = 4'h0;
    localparam logic [3:0]  OFS_FLAGS        = 4'h1;
    localparam logic [3:0]  OFS_PENDING      = 4'h2;
    // implemented bits of the mask and flag registers
    localparam logic [31:0] MASK_IMPL        = 32'h00ff_7cfe | 32'h0000_0001;
    localparam logic [31:0] FLAG_IMPL        = 32'h00ff_7cfe;
    localparam logic [31:0] MASK_RESET       = 32'h0000_0000;
    // field positions
    localparam int          POS_LONG_FIELD_B     = 23;
    localparam int          POS_SHORT_FIELD_B    = 22;
    localparam int          POS_VERT_FIELD2_B    = 21;
    localparam int          POS_VERT_FIELD1_B    = 20;
    localparam int          POS_SYNC_ERROR_B     = 19;
    localparam int          POS_CAPTURE_DONE_B   = 18;
    localparam int          POS_CAPTURE_OVERRUN_B = 17;
    localparam int          POS_GPIO             = 16;
    localparam int          POS_DISPLAY_UNACKED  = 14;
    localparam int          POS_DISPLAY_DONE     = 13;
    localparam int          POS_DISPLAY_UNDERRUN = 12;
    localparam int          POS_TIME_TICK        = 11;
    localparam int          POS_TIME_MATCH       = 10;
    localparam int          POS_LONG_FIELD_A     = 7;
    localparam int          POS_CAPTURE_OVERRUN_A = 1;
    localparam int          POS_GLOBAL_EN        = 0;
    localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;
endpackage : video_interrupt_mask_pkg

/* File: design/video_interrupt_mask_gate.sv */
// per-source gating of pending flags by the enable mask
`timescale 1ns/100ps
module video_interrupt_mask_gate
    import video_interrupt_mask_pkg::*;
(
    // inputs
    input  wire logic [31:0] flags,
    input  wire logic [31:0] mask,
    // outputs
    output logic      [31:0] pending,
    output logic             any_pending
);
    assign pending     = flags & mask & FLAG_IMPL;
    assign any_pending = (|pending) & mask[POS_GLOBAL_EN];
endmodule : video_interrupt_mask_gate

/* File: design/video_interrupt_mask_top.sv */
// interrupt enable register of the video port with interrupt line gating
`timescale 1ns/100ps
// Summary of operation
// - reserved bits 31..24, 15, 9..8 read zero; writes there ignored
// - every implemented enable bit clears to zero at reset
// - enable register is a per-source mask, each implemented bit readable and writable
// - bit 23 enables channel B long field source
// - bit 22 enables channel B short field source
// - bit 21 enables channel B field two vertical source
// - bit 20 enables channel B field one vertical source
// - bit 19 enables channel B sync error source
// - bit 18 enables channel B capture complete source
// - bit 17 enables channel B capture overrun source
// - bit 16 enables general purpose pin source
// - bit 14 enables display complete not acknowledged source
// - bit 13 enables display complete source
// - bit 12 enables display underrun source
// - bit 11 enables time clock tick source
// - bit 10 enables time clock match source
// - bits 7..1 enable channel A sources in channel B order
// - bit 0 global enable must be set for any interrupt
// - a pending flag reaches the interrupt only while its enable is set
module video_interrupt_mask_top
    import video_interrupt_mask_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // register port
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [DATA_W-1:0]  reg_rdata,
    // interrupt sources and output
    input  wire logic [31:0]        video_interrupt_flags,
    output logic                    irq_out
);
    import video_interrupt_mask_pkg::*;

    logic [31:0] video_interrupt_mask_reg;
    logic [31:0] video_interrupt_mask_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] pending;
    logic        any_pending;
    logic        irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // register write

    wire         wr_mask = reg_wr && (reg_addr == OFS_MASK);
    // only implemented bits take a write
    assign video_interrupt_mask_next = wr_mask ? (reg_wdata & MASK_IMPL)
                                               : video_interrupt_mask_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            video_interrupt_mask_reg <= MASK_RESET;
        end else begin
            video_interrupt_mask_reg <= video_interrupt_mask_next;
        end
    end

    // named enables, one per source, except channel A sources which share the vector chan_a_en
    wire long_field_b_en       = video_interrupt_mask_reg[POS_LONG_FIELD_B];
    wire short_field_b_en      = video_interrupt_mask_reg[POS_SHORT_FIELD_B];
    wire vert_field2_b_en      = video_interrupt_mask_reg[POS_VERT_FIELD2_B];
    wire vert_field1_b_en      = video_interrupt_mask_reg[POS_VERT_FIELD1_B];
    wire sync_error_b_en       = video_interrupt_mask_reg[POS_SYNC_ERROR_B];
    wire capture_done_b_en     = video_interrupt_mask_reg[POS_CAPTURE_DONE_B];
    wire capture_overrun_b_en  = video_interrupt_mask_reg[POS_CAPTURE_OVERRUN_B];
    wire gpio_en               = video_interrupt_mask_reg[POS_GPIO];
    wire display_done_unacked_en = video_interrupt_mask_reg[POS_DISPLAY_UNACKED];
    wire display_done_en       = video_interrupt_mask_reg[POS_DISPLAY_DONE];
    wire display_underrun_en   = video_interrupt_mask_reg[POS_DISPLAY_UNDERRUN];
    wire time_tick_en          = video_interrupt_mask_reg[POS_TIME_TICK];
    wire time_clock_match_en   = video_interrupt_mask_reg[POS_TIME_MATCH];
    wire [6:0] chan_a_en       = video_interrupt_mask_reg[POS_LONG_FIELD_A:POS_CAPTURE_OVERRUN_A];
    wire global_interrupt_en   = video_interrupt_mask_reg[POS_GLOBAL_EN];

    ////////////////////////////////////////////////////////////////////////////
    // gating

    video_interrupt_mask_gate u_gate (
        .flags       (video_interrupt_flags),
        .mask        (video_interrupt_mask_reg),
        .pending     (pending),
        .any_pending (any_pending)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= any_pending;
        end
    end
    assign irq_out = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // register read

    wire [31:0] rd_mux = (reg_addr == OFS_MASK)    ? video_interrupt_mask_reg :
                         (reg_addr == OFS_FLAGS)   ? (video_interrupt_flags & FLAG_IMPL) :
                         (reg_addr == OFS_PENDING) ? pending : DATA_ZERO;
    assign rdata_next = reg_rd ? rd_mux : DATA_ZERO;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_reg <= DATA_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        (video_interrupt_mask_reg & ~MASK_IMPL) == DATA_ZERO)
        else $error("reserved mask bit set");

    a_reset_clear: assert property (@(posedge clk)
        !resetn |=> video_interrupt_mask_reg == MASK_RESET)
        else $error("mask not cleared by reset");

    a_write_reads_back: assert property (@(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == OFS_MASK) ##1 (reg_rd && reg_addr == OFS_MASK)
        |=> reg_rdata == ($past(reg_wdata, 2) & MASK_IMPL))
        else $error("mask readback mismatch");

    a_chan_b_long: assert property (@(posedge clk) disable iff (!resetn)
        (video_interrupt_flags[POS_LONG_FIELD_B] && long_field_b_en && global_interrupt_en)
        |=> irq_out)
        else $error("long field b did not raise interrupt");

    a_global_gate: assert property (@(posedge clk) disable iff (!resetn)
        !global_interrupt_en |=> !irq_out)
        else $error("interrupt without global enable");

    a_masked_source: assert property (@(posedge clk) disable iff (!resetn)
        ((video_interrupt_flags & video_interrupt_mask_reg & FLAG_IMPL) == DATA_ZERO)
        |=> !irq_out)
        else $error("interrupt from masked source");

    a_irq_follows: assert property (@(posedge clk) disable iff (!resetn)
        (global_interrupt_en && (|(video_interrupt_flags & video_interrupt_mask_reg & FLAG_IMPL)))
        |=> irq_out)
        else $error("enabled pending source missed");

    a_chan_a_order: assert property (@(posedge clk) disable iff (!resetn)
        (video_interrupt_flags[POS_CAPTURE_OVERRUN_A] && chan_a_en[0] && global_interrupt_en)
        |=> irq_out)
        else $error("channel a overrun did not raise interrupt");

    a_read_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
        !reg_rd |=> reg_rdata == DATA_ZERO)
        else $error("read data outside read cycle");

endmodule : video_interrupt_mask_top

/* File: tb/vim_flag_src.sv */
// status flag model: sets on request, clears on write of one
`timescale 1ns/100ps
module vim_flag_src (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // set and clear requests
    input  wire logic [31:0] set_bits,
    input  wire logic [31:0] clr_bits,
    // flags towards the enable block
    output logic      [31:0] flags
);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags <= 32'h0000_0000;
        end else begin
            flags <= (flags & ~clr_bits) | set_bits;
        end
    end
endmodule : vim_flag_src

/* File: tb/tb_top.sv */
// self-checking bench of the interrupt enable block
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    import video_interrupt_mask_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] flags;
    logic [31:0] set_bits = 32'h0000_0000;
    logic [31:0] clr_bits = 32'h0000_0000;
    logic        irq_out;
    logic [31:0] rv;
    int          err_total = 0;
    int          checked = 0;
    always #2 clk = ~clk;
    vim_flag_src src (.clk(clk), .resetn(resetn), .set_bits(set_bits),
                      .clr_bits(clr_bits), .flags(flags));
    video_interrupt_mask_top dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
                  .video_interrupt_flags(flags), .irq_out(irq_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wr
    // read data is sampled in the one cycle it stands
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic flg(input logic [31:0] v);
        @(posedge clk);
        clr_bits <= 32'hffff_ffff;
        set_bits <= v;
        @(posedge clk);
        clr_bits <= 32'h0000_0000;
        set_bits <= 32'h0000_0000;
        repeat (2) @(posedge clk);
    endtask : flg
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(4 * 20000);
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd(OFS_MASK, rv);
        `CHK(rv, 32'h0000_0000)
        $display("reset test done");
        wr(OFS_MASK, 32'hffff_ffff);
        rd(OFS_MASK, rv);
        `CHK(rv, 32'h00ff_7cff)
        @(negedge clk);
        `CHK(reg_rdata, 32'h0000_0000)
        wr(OFS_FLAGS, 32'h0000_0000);
        rd(OFS_MASK, rv);
        `CHK(rv, 32'h00ff_7cff)
        rd(4'hf, rv);
        `CHK(rv, 32'h0000_0000)
        // write strobe followed at once by a read strobe
        reg_addr  <= OFS_MASK;
        reg_wdata <= 32'h1234_5678;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        @(negedge clk);
        `CHK(reg_rdata, 32'h0034_5478)
        @(posedge clk);
        $display("access test done");
        for (int i = 0; i < 32; i++) begin
            wr(OFS_MASK, 32'hffff_ffff);
            flg(32'h0000_0001 << i);
            `CHK(irq_out, FLAG_IMPL[i])
            wr(OFS_MASK, 32'hffff_ffff & ~(32'h0000_0001 << i) | 32'h0000_0001);
            `CHK(irq_out, 1'b0)
        end
        $display("source test done");
        flg(32'hffff_ffff);
        wr(OFS_MASK, 32'h00ff_7cfe);
        `CHK(irq_out, 1'b0)
        wr(OFS_MASK, 32'h0000_0001);
        `CHK(irq_out, 1'b0)
        wr(OFS_MASK, 32'h0000_0401);
        `CHK(irq_out, 1'b1)
        flg(32'h0000_0000);
        `CHK(irq_out, 1'b0)
        $display("global test done");
        wr(OFS_MASK, 32'hffff_ffff);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(OFS_MASK, rv);
        `CHK(rv, 32'h0000_0000)
        `CHK(irq_out, 1'b0)
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule : tb_top
